// [vrc_top.v]
// fixed reference control: apb registers, enable logic, ready timer, gain paths
// Operation
// - control bit 7 written one switches the reference on; cleared switches it off.
// - ready bit 6 sets only after reference and amplifiers stabilise.
// - two independent gain settings, converter and comparator, each 1x, 2x or 4x.
// - comparator field bits 3:2: 11 gives 4.096V, 10 2.048V, 01 1.024V.
// - converter field bits 1:0 uses the same mapping, independently.
// - reference output feeds converter channel and either comparator input.
// - reference held on for internal HF oscillator as system clock, not sleeping.
// - brown-out mode 11 holds it on; 10 or 01 with fast start too, 10 not asleep.
// - regulator power-mode one holds reference on outside sleep.
// - temperature enable bit powers the indicator; cleared it draws nothing.
// - range bit set selects high range, cleared low range.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "vrc_regs.vh"
module vrc_top #(
  parameter STAB_CYCLES = `VRC_STAB_CYCLES,
  parameter CNT_W       = 16
) (
  input  wire        pclk,            // system clock
  input  wire        presetn,         // async reset, low
  input  wire        psel,            // apb select
  input  wire        penable,         // apb enable
  input  wire        pwrite,          // apb direction
  input  wire [11:0] paddr,           // apb byte address
  input  wire [31:0] pwdata,          // apb write data
  output reg  [31:0] prdata,          // apb read data
  output reg         pready,          // apb ready
  output reg         pslverr,         // apb error
  input  wire        sleep,           // device in sleep
  input  wire [1:0]  clk_source_sel,  // system clock source select
  input  wire [3:0]  internal_osc_freq_select, // oscillator frequency code
  input  wire [1:0]  brownout_enable_mode,     // brown-out mode
  input  wire        brownout_fast_start,      // brown-out fast start
  input  wire        regulator_power_mode,     // regulator mode
  output reg         ref_on,          // reference powered
  output reg         reference_ready, // reference stable
  output reg  [2:0]  cnv_level,       // converter level one-hot
  output reg  [2:0]  cmp_level,       // comparator level one-hot
  output reg         cnv_ref_valid,   // converter channel may use reference
  output reg         cmp_pos_valid,   // comparator plus input may use reference
  output reg         cmp_neg_valid,   // comparator minus input may use reference
  output reg         temp_indicator_enable, // indicator powered
  output reg         temp_range_select,     // high range
  output reg         irq              // interrupt level
);
  // ==========================================================================
  // registers
  reg  [7:0]                ctrl;
  reg  [`VRC_IRQ_BITS-1:0]  irq_status;
  reg  [`VRC_IRQ_BITS-1:0]  irq_enable;
  reg                       ready_d;
  wire                      ready_now;
  wire [2:0]                cnv_lvl_w;
  wire [2:0]                cmp_lvl_w;
  wire                      req_osc;
  wire                      req_bor;
  wire                      req_ldo;
  wire                      next_ref_on;
  wire                      wr;
  wire                      rd;
  wire                      mapped;
  wire [`VRC_IRQ_BITS-1:0]  ev;
  wire [`VRC_IRQ_BITS-1:0]  clr;
  // ==========================================================================
  // system requests holding the reference on
  assign req_osc = (clk_source_sel == `VRC_CLKSEL_INTERNAL_OSC)
                 && (internal_osc_freq_select[3:1] == `VRC_IRCF_HF) && !sleep;
  assign req_bor = (brownout_enable_mode == `VRC_BOR_ON)
                 || (brownout_enable_mode == `VRC_BOR_SLEEP_OFF
                     && brownout_fast_start && !sleep)
                 || (brownout_enable_mode == `VRC_BOR_SOFT && brownout_fast_start);
  assign req_ldo = regulator_power_mode && !sleep;
  assign next_ref_on = ctrl[`VRC_BIT_ENABLE] || req_osc || req_bor || req_ldo;
  // ==========================================================================
  // apb decode
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign mapped = (paddr == `VRC_OFF_CTRL) || (paddr == `VRC_OFF_IRQ_STATUS)
               || (paddr == `VRC_OFF_IRQ_ENABLE) || (paddr == `VRC_OFF_IRQ_CLEAR)
               || (paddr == `VRC_OFF_SYSREQ);
  assign clr    = (wr && paddr == `VRC_OFF_IRQ_CLEAR) ? pwdata[`VRC_IRQ_BITS-1:0]
                                                      : {`VRC_IRQ_BITS{1'b0}};
  assign ev     = {ready_d & ~ready_now, ~ready_d & ready_now};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= `VRC_CTRL_RESET;
      irq_enable <= {`VRC_IRQ_BITS{1'b0}};
      irq_status <= {`VRC_IRQ_BITS{1'b0}};
      ready_d    <= 1'b0;
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      ready_d    <= ready_now;
      irq_status <= (irq_status & ~clr) | ev;   // set wins over clear
      pready     <= psel && !penable;
      pslverr    <= psel && !penable && !mapped;
      if (wr && paddr == `VRC_OFF_CTRL) begin
        ctrl <= pwdata[7:0] & `VRC_CTRL_WMASK;
      end
      if (wr && paddr == `VRC_OFF_IRQ_ENABLE) begin
        irq_enable <= pwdata[`VRC_IRQ_BITS-1:0];
      end
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `VRC_OFF_CTRL:
            prdata <= {24'h000000, ctrl[7], ready_now, ctrl[5:0]};
          `VRC_OFF_IRQ_STATUS: prdata <= {30'h00000000, irq_status};
          `VRC_OFF_IRQ_ENABLE: prdata <= {30'h00000000, irq_enable};
          `VRC_OFF_SYSREQ:     prdata <= {28'h0000000, ref_on, req_ldo, req_bor, req_osc};
          default:             prdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ==========================================================================
  // reference power, stabilisation and gain paths
  vrc_stab_timer #(
    .CNT_W  (CNT_W),
    .CYCLES (STAB_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ref_on),
    .ready   (ready_now)
  );
  vrc_gain_path u_cmp (
    .pclk    (pclk),
    .presetn (presetn),
    .ref_on  (next_ref_on),
    .code    (ctrl[`VRC_CMP_HI:`VRC_CMP_LO]),
    .level   (cmp_lvl_w)
  );
  vrc_gain_path u_cnv (
    .pclk    (pclk),
    .presetn (presetn),
    .ref_on  (next_ref_on),
    .code    (ctrl[`VRC_CNV_HI:`VRC_CNV_LO]),
    .level   (cnv_lvl_w)
  );
  // ==========================================================================
  // outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_on                <= 1'b0;
      reference_ready       <= 1'b0;
      cnv_level             <= 3'h0;
      cmp_level             <= 3'h0;
      cnv_ref_valid         <= 1'b0;
      cmp_pos_valid         <= 1'b0;
      cmp_neg_valid         <= 1'b0;
      temp_indicator_enable <= 1'b0;
      temp_range_select     <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      ref_on                <= next_ref_on;
      reference_ready       <= ready_now;
      cnv_level             <= cnv_lvl_w;
      cmp_level             <= cmp_lvl_w;
      cnv_ref_valid         <= ready_now && (cnv_lvl_w != 3'h0);
      cmp_pos_valid         <= ready_now && (cmp_lvl_w != 3'h0);
      cmp_neg_valid         <= ready_now && (cmp_lvl_w != 3'h0);
      temp_indicator_enable <= ctrl[`VRC_BIT_TEMP_EN];
      temp_range_select     <= ctrl[`VRC_BIT_TEMP_RNG];
      irq                   <= |(irq_status & irq_enable);
    end
  end
endmodule

// [vrc_regs.vh]
// register map, field positions, reset values and timing counts of the reference control block
`ifndef VRC_REGS_VH
`define VRC_REGS_VH
// ==========================================================================
// register byte offsets
`define VRC_OFF_CTRL        12'h000
`define VRC_OFF_IRQ_STATUS  12'h004
`define VRC_OFF_IRQ_ENABLE  12'h008
`define VRC_OFF_IRQ_CLEAR   12'h00C
`define VRC_OFF_SYSREQ      12'h010
// ==========================================================================
// control register fields
`define VRC_BIT_ENABLE      7
`define VRC_BIT_READY       6
`define VRC_BIT_TEMP_EN     5
`define VRC_BIT_TEMP_RNG    4
`define VRC_CMP_HI          3
`define VRC_CMP_LO          2
`define VRC_CNV_HI          1
`define VRC_CNV_LO          0
`define VRC_CTRL_RESET      8'h00
`define VRC_CTRL_WMASK      8'hBF
// ==========================================================================
// gain codes
`define VRC_GAIN_OFF        2'h0
`define VRC_GAIN_1X         2'h1
`define VRC_GAIN_2X         2'h2
`define VRC_GAIN_4X         2'h3
// ==========================================================================
// system request encodings
`define VRC_BOR_ON          2'h3
`define VRC_BOR_SLEEP_OFF   2'h2
`define VRC_BOR_SOFT        2'h1
`define VRC_CLKSEL_INTERNAL_OSC   2'h0
`define VRC_IRCF_HF         3'h0
// ==========================================================================
// interrupt bits: 0 ready rose, 1 ready fell
`define VRC_IRQ_BITS        2
// ==========================================================================
// stabilisation time
`define VRC_STAB_TIME_NS    25000
`define VRC_CLK_PERIOD_NS   5
`define VRC_STAB_CYCLES     ((`VRC_STAB_TIME_NS + `VRC_CLK_PERIOD_NS - 1) / `VRC_CLK_PERIOD_NS)
`endif

// [vrc_stab_timer.v]
// stabilisation timer: ready rises after a fixed count of enabled cycles
`timescale 1ns/1ps
module vrc_stab_timer #(
  parameter CNT_W  = 16,
  parameter CYCLES = 5000
) (
  input  wire pclk,     // system clock
  input  wire presetn,  // async reset, low
  input  wire run,      // reference powered
  output reg  ready     // stable
);
  reg [CNT_W-1:0] count;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {CNT_W{1'b0}};
      ready <= 1'b0;
    end else if (!run) begin
      count <= {CNT_W{1'b0}};
      ready <= 1'b0;
    end else if (count == CYCLES[CNT_W-1:0] - 1'b1) begin
      ready <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

// [vrc_gain_path.v]
// one gain path: decodes a 2-bit gain code into a one-hot level select
`timescale 1ns/1ps
`include "vrc_regs.vh"
module vrc_gain_path (
  input  wire       pclk,     // system clock
  input  wire       presetn,  // async reset, low
  input  wire       ref_on,   // reference powered
  input  wire [1:0] code,     // gain code
  output reg  [2:0] level     // one-hot 4x,2x,1x
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 3'h0;
    end else if (!ref_on) begin
      level <= 3'h0;
    end else begin
      case (code)
        `VRC_GAIN_4X: level <= 3'h4;
        `VRC_GAIN_2X: level <= 3'h2;
        `VRC_GAIN_1X: level <= 3'h1;
        `VRC_GAIN_OFF: level <= 3'h0;
        default:      level <= 3'h0;
      endcase
    end
  end
endmodule

// [vrc_top_asserts.sv]
// port assertions for the reference control block
`timescale 1ns/1ps
module vrc_chk (
  input wire        pclk,                     // clock
  input wire        presetn,                  // reset low
  input wire        psel,                     // select
  input wire        penable,                  // enable
  input wire        pwrite,                   // direction
  input wire [11:0] paddr,                    // address
  input wire [31:0] pwdata,                   // write data
  input wire        pready,                   // ready
  input wire        sleep,                    // sleep
  input wire [1:0]  clk_source_sel,           // clock source
  input wire [3:0]  internal_osc_freq_select, // osc code
  input wire [1:0]  brownout_enable_mode,     // bor mode
  input wire        brownout_fast_start,      // fast start
  input wire        regulator_power_mode,     // ldo mode
  input wire        ref_on,                   // powered
  input wire        reference_ready,          // stable
  input wire [2:0]  cnv_level,                // converter level
  input wire [2:0]  cmp_level,                // comparator level
  input wire        cmp_pos_valid,            // plus input
  input wire        cmp_neg_valid             // minus input
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_en_write: assert property (psel && penable && pready && pwrite && paddr == 12'h000
    && pwdata[7] |-> ##[1:2] ref_on) else $error("reference off after enable write");
  chk_ready_wait: assert property ($rose(reference_ready) |-> $past(ref_on, 8))
    else $error("ready before stabilisation");
  chk_ready_off: assert property (!ref_on [*3] |-> !reference_ready)
    else $error("ready while reference off");
  chk_level_onehot: assert property ($onehot0(cnv_level) && $onehot0(cmp_level))
    else $error("gain level not one-hot");
  chk_cmp_pair: assert property (cmp_pos_valid == cmp_neg_valid)
    else $error("comparator inputs differ");
  chk_osc_req: assert property (clk_source_sel == 2'h0 && !sleep
    && internal_osc_freq_select[3:1] == 3'h0 |=> ref_on) else $error("osc request lost");
  chk_bor_req: assert property (brownout_enable_mode == 2'h3 || brownout_fast_start
    && (brownout_enable_mode == 2'h1 || brownout_enable_mode == 2'h2 && !sleep) |=> ref_on)
    else $error("brown-out request lost");
  chk_ldo_req: assert property (regulator_power_mode && !sleep |=> ref_on)
    else $error("regulator request lost");
endmodule

// [vrc_ref_sink.sv]
// reference consumer: level seen on a converter or comparator input
`timescale 1ns/1ps
module vrc_ref_sink (
  input  wire [2:0]  level, // one-hot gain
  input  wire        valid, // usable
  output wire [12:0] mv     // millivolts seen
);
  // nothing usable until ready
  assign mv = valid ? {level, 10'h000} : 13'h0000;
endmodule

// [voltage_reference_control_tb_top.sv]
// testbench for the reference control block
`timescale 1ns/1ps
module voltage_reference_control_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, sleep, fs, ldo;
  logic [11:0] paddr;
  logic [31:0] pwdata, prd;
  logic [3:0]  freq;
  logic [1:0]  csel, bor;
  wire  [31:0] prdata;
  wire         pready, pslverr, ref_on, rdy, cnv_v, cmp_p, cmp_n, tie, tr, irq;
  wire  [2:0]  cnv_level, cmp_level;
  wire  [12:0] cnv_mv, cmp_mv;
  logic        perr;
  logic [13:0] rows [6];
  logic [11:0] sys [10];
  logic [13:0] r;
  integer      i, n, n_errors, cmp_count;
  vrc_top #(.STAB_CYCLES(8)) vrc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep(sleep), .clk_source_sel(csel),
    .internal_osc_freq_select(freq), .brownout_enable_mode(bor), .brownout_fast_start(fs),
    .regulator_power_mode(ldo), .ref_on(ref_on), .reference_ready(rdy),
    .cnv_level(cnv_level), .cmp_level(cmp_level), .cnv_ref_valid(cnv_v),
    .cmp_pos_valid(cmp_p), .cmp_neg_valid(cmp_n), .temp_indicator_enable(tie),
    .temp_range_select(tr), .irq(irq));
  vrc_ref_sink cnv_sink_i (.level(cnv_level), .valid(cnv_v), .mv(cnv_mv));
  vrc_ref_sink cmp_sink_i (.level(cmp_level), .valid(cmp_p), .mv(cmp_mv));
  always #2.5 pclk = ~pclk;
  task chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // setup, then hold the access until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, fs, ldo, freq, bor} = 0;
    {sleep, csel, n_errors, cmp_count} = {1'b1, 2'h1, 64'h0};
    rows = '{{8'h81, 3'h1, 3'h0}, {8'h86, 3'h2, 3'h1}, {8'hBB, 3'h4, 3'h2},
             {8'h9C, 3'h0, 3'h4}, {8'hA0, 3'h0, 3'h0}, {8'hE7, 3'h4, 3'h1}};
    sys = '{12'h203, 12'hA02, 12'hA19, 12'hA14, 12'h215, 12'hA0D, 12'h208, 12'h021,
            12'h040, 12'h800};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(prd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({prd, perr}, 33'h1);
    apb(1'b1, 12'h000, 32'h80);
    apb(1'b0, 12'h000, 32'h0);
    chk(prd, 32'h80);
    for (n = 0; rdy !== 1'b1 && n < 40; n = n + 1) @(posedge pclk);
    chk(n >= 6 && n < 40, 1);
    for (i = 0; i < 6; i = i + 1) begin
      r = rows[i];
      apb(1'b1, 12'h000, {24'h0, r[13:6]});
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(prd, {24'h0, r[13:6] & 8'hBF | 8'h40});
      chk({cnv_level, cmp_level}, r[5:0]);
      chk({cnv_mv, cmp_mv}, {r[5:3], 10'h000, r[2:0], 10'h000});
      chk({tie, tr}, r[11:10]);
      chk({cnv_v, cmp_p, cmp_n}, {r[5:3] != 3'h0, {2{r[2:0] != 3'h0}}});
    end
    apb(1'b1, 12'h000, 32'h4F);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk({prd, ref_on, rdy, cnv_level}, {32'h0F, 5'h0});
    chk(irq, 0);
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk({prd, irq}, 33'h7);
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk({prd, irq}, 33'h0);
    for (i = 0; i < 10; i = i + 1) begin
      {sleep, csel, freq, bor, fs, ldo} <= sys[i][11:1];
      repeat (3) @(posedge pclk);
      chk(ref_on, sys[i][0]);
      apb(1'b0, 12'h010, 32'h0);
      chk(prd[3], sys[i][0]);
    end
    // mid-run reset with the reference enabled
    apb(1'b1, 12'h000, 32'hBF);
    repeat (2) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({ref_on, rdy, cnv_level, cmp_level, tie, tr, irq, pready}, 40'h0);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(prd, 32'h0);
    results;
  end
endmodule
bind vrc_top vrc_chk vrc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .sleep(sleep), .clk_source_sel(clk_source_sel), .regulator_power_mode(regulator_power_mode),
  .internal_osc_freq_select(internal_osc_freq_select), .ref_on(ref_on),
  .brownout_enable_mode(brownout_enable_mode), .brownout_fast_start(brownout_fast_start),
  .reference_ready(reference_ready), .cnv_level(cnv_level), .cmp_level(cmp_level),
  .cmp_pos_valid(cmp_pos_valid), .cmp_neg_valid(cmp_neg_valid));
